// *** hdl/fcs_fanout.sv ***
`timescale 1ns/1ps
`include "fcs_params.svh"

// Functional notes
// [RULE_01] Source choice 0 routes the differential reference, 1 routes the oscillator input.
// [RULE_02] The crystal oscillator stays powered down while the differential input is chosen.
// [RULE_03] With the oscillator input chosen the oscillator runs and feeds every output.
// [RULE_04] One chosen clock drives all five outputs alike.
// [RULE_05] Static differential input gives low for open or both low, else the true leg's level; the code also gives low when both legs are high.
// [RULE_06] Static oscillator input in crystal mode gives the inverse level at the outputs.
// [RULE_07] The oscillator input must not be left open in crystal mode.
// [RULE_08] A single-ended clock of at most 200 MHz may replace the crystal.
// [RULE_09] Outputs are enabled while the enable pin is high and high impedance while low.
// [RULE_10] After enable rises outputs sit on a weak pull-down until the second falling edge.
// [RULE_11] Enabling with no input clock leaves the outputs static, never oscillating.
// [RULE_12] After enable falls outputs go low at the second falling edge, then off at next rise.
// [RULE_13] Edges are counted on the chosen source and the count restarts on each enable change.

module fcs_fanout #(
	parameter int NUM_OUT    = `FCS_NUM_OUT,
	parameter int EDGE_COUNT = `FCS_EDGE_COUNT
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// Pin controls
	input  wire logic                 sel_i,
	input  wire logic                 oe_i,
	input  wire fcs_pkg::fcs_clk_in_t clk_in_i,
	// Crystal interface
	output logic                      xtal_osc_en_o,
	output logic                      xtal_drive_out_o,
	// Fanout outputs
	output logic [NUM_OUT-1:0]        fanout_clk_o,
	output logic [NUM_OUT-1:0]        fanout_clk_oe_o,
	output logic                      fanout_pd_o
);

	// Two-bit edge counter, so more than three edges cannot be served
	if (NUM_OUT < 1 || EDGE_COUNT < 1 || EDGE_COUNT > 3) begin : g_bad_params
		$error("fcs_fanout: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// Input sampling

	fcs_pkg::fcs_clk_in_t in_reg, in_next;
	logic sel_reg, sel_next;
	logic oe_reg, oe_next;
	logic oe_prev_reg, oe_prev_next;
	logic src_prev_reg, src_prev_next;
	logic src;
	logic fall;
	logic rise;
	logic oe_chg;

	always_comb begin
		in_next       = clk_in_i;
		sel_next      = sel_i;
		oe_next       = oe_i;
		oe_prev_next  = oe_reg;
		src_prev_next = src;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			in_reg       <= '0;
			sel_reg      <= 1'b0;
			oe_reg       <= 1'b0;
			oe_prev_reg  <= 1'b0;
			src_prev_reg <= 1'b0;
		end else begin
			in_reg       <= in_next;
			sel_reg      <= sel_next;
			oe_reg       <= oe_next;
			oe_prev_reg  <= oe_prev_next;
			src_prev_reg <= src_prev_next;
		end
	end

	// Open legs read as low, so open/open lands on low
	always_comb begin
		if (sel_reg == `FCS_SEL_XTAL)
			src = ~in_reg.xtal_in; // RULE_01 RULE_06
		else
			src = in_reg.diff_ref_in_p & ~in_reg.diff_ref_in_n; // RULE_01 RULE_05
	end

	// Edges of the chosen source only
	assign fall   = src_prev_reg & ~src; // RULE_13
	assign rise   = ~src_prev_reg & src;
	assign oe_chg = oe_reg != oe_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// Enable sequencer

	fcs_pkg::fcs_state_t state_reg, state_next;
	logic [`FCS_CNT_W-1:0] cnt_reg, cnt_next;
	logic [`FCS_CNT_W-1:0] last_cnt;
	logic [NUM_OUT-1:0] data_reg, data_next;
	logic [NUM_OUT-1:0] drv_reg, drv_next;
	logic pd_reg, pd_next;
	logic osc_reg, osc_next;
	logic xdrv_reg, xdrv_next;

	assign last_cnt = `FCS_CNT_W'(EDGE_COUNT - 1);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			fcs_pkg::FCS_ST_OFF: begin
				if (oe_reg)
					state_next = fcs_pkg::FCS_ST_EN_WAIT; // RULE_10
			end
			fcs_pkg::FCS_ST_EN_WAIT: begin
				if (!oe_reg)
					state_next = fcs_pkg::FCS_ST_OFF;
				else if (fall && !oe_chg) begin
					// No source edges means we wait here, outputs static
					if (cnt_reg == last_cnt)
						state_next = fcs_pkg::FCS_ST_RUN; // RULE_10 RULE_11
					else
						cnt_next = cnt_reg + 1'b1;
				end
			end
			fcs_pkg::FCS_ST_RUN: begin
				if (!oe_reg)
					state_next = fcs_pkg::FCS_ST_DIS_WAIT; // RULE_12
			end
			fcs_pkg::FCS_ST_DIS_WAIT: begin
				if (oe_reg)
					state_next = fcs_pkg::FCS_ST_RUN;
				else if (fall && !oe_chg) begin
					if (cnt_reg == last_cnt)
						state_next = fcs_pkg::FCS_ST_DIS_LOW; // RULE_12
					else
						cnt_next = cnt_reg + 1'b1;
				end
			end
			fcs_pkg::FCS_ST_DIS_LOW: begin
				if (oe_reg)
					state_next = fcs_pkg::FCS_ST_EN_WAIT;
				else if (rise)
					state_next = fcs_pkg::FCS_ST_OFF; // RULE_12
			end
			default: begin
				state_next = fcs_pkg::FCS_ST_OFF;
			end
		endcase
		if (oe_chg || state_next != state_reg)
			cnt_next = '0; // RULE_13
	end

	// Output pin drive, all lanes identical
	always_comb begin
		data_next = '0;
		drv_next  = '0;
		pd_next   = 1'b0;
		case (state_next)
			fcs_pkg::FCS_ST_RUN, fcs_pkg::FCS_ST_DIS_WAIT: begin
				data_next = {NUM_OUT{src}}; // RULE_04 RULE_09
				drv_next  = '1;
			end
			fcs_pkg::FCS_ST_DIS_LOW: begin
				drv_next  = '1; // RULE_12
			end
			fcs_pkg::FCS_ST_EN_WAIT: begin
				pd_next   = 1'b1; // RULE_10
			end
			default: begin
				drv_next  = '0; // RULE_09
			end
		endcase
		// Oscillator amp only alive in crystal mode
		osc_next  = sel_reg == `FCS_SEL_XTAL; // RULE_02 RULE_03
		xdrv_next = osc_next & ~in_reg.xtal_in;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= fcs_pkg::FCS_ST_OFF;
			cnt_reg   <= '0;
			data_reg  <= '0;
			drv_reg   <= '0;
			pd_reg    <= 1'b0;
			osc_reg   <= 1'b0;
			xdrv_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			data_reg  <= data_next;
			drv_reg   <= drv_next;
			pd_reg    <= pd_next;
			osc_reg   <= osc_next;
			xdrv_reg  <= xdrv_next;
		end
	end

	assign fanout_clk_o     = data_reg;
	assign fanout_clk_oe_o  = drv_reg;
	assign fanout_pd_o      = pd_reg;
	assign xtal_osc_en_o    = osc_reg;
	assign xtal_drive_out_o = xdrv_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_diff_route;
		(state_reg == fcs_pkg::FCS_ST_RUN && $past(state_next) == fcs_pkg::FCS_ST_RUN
			&& $past(sel_reg) == `FCS_SEL_DIFF)
			|-> fanout_clk_o[0] == $past(in_reg.diff_ref_in_p & ~in_reg.diff_ref_in_n);
	endproperty
	a_diff_route: assert property (p_diff_route) else $error("diff map wrong"); // RULE_05

	property p_xtal_inv;
		(state_reg == fcs_pkg::FCS_ST_RUN && $past(sel_reg) == `FCS_SEL_XTAL)
			|-> fanout_clk_o[0] == !$past(in_reg.xtal_in);
	endproperty
	a_xtal_inv: assert property (p_xtal_inv) else $error("xtal not inverted"); // RULE_06

	property p_osc_off;
		sel_reg == `FCS_SEL_DIFF |=> !xtal_osc_en_o && !xtal_drive_out_o;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("osc on in diff mode"); // RULE_02

	property p_osc_on;
		sel_reg == `FCS_SEL_XTAL |=> xtal_osc_en_o;
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("osc off in xtal mode"); // RULE_03

	property p_lanes_equal;
		fanout_clk_o == {NUM_OUT{fanout_clk_o[0]}}
			&& fanout_clk_oe_o == {NUM_OUT{fanout_clk_oe_o[0]}};
	endproperty
	a_lanes_equal: assert property (p_lanes_equal) else $error("lanes differ"); // RULE_04

	property p_off_hiz;
		!oe_reg && state_reg == fcs_pkg::FCS_ST_OFF
			|=> fanout_clk_oe_o == '0 && !fanout_pd_o;
	endproperty
	a_off_hiz: assert property (p_off_hiz) else $error("run while enable low"); // RULE_09

	property p_en_pull;
		$rose(oe_reg) ##1 !fall |=> fanout_pd_o && fanout_clk_oe_o == '0;
	endproperty
	a_en_pull: assert property (p_en_pull) else $error("no pull after enable"); // RULE_10

	property p_dis_low;
		state_reg == fcs_pkg::FCS_ST_DIS_LOW |-> fanout_clk_oe_o == '1 && fanout_clk_o == '0;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("not low before hiz"); // RULE_12

	property p_restart;
		$changed(oe_reg) |=> cnt_reg == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("count not restarted"); // RULE_13

	property p_run_drive;
		state_reg == fcs_pkg::FCS_ST_RUN |-> fanout_clk_oe_o == '1 && !fanout_pd_o;
	endproperty
	a_run_drive: assert property (p_run_drive) else $error("not driving in run"); // RULE_09

	property p_pd_excl;
		fanout_pd_o |-> fanout_clk_oe_o == '0 && fanout_clk_o == '0;
	endproperty
	a_pd_excl: assert property (p_pd_excl) else $error("pull while driving"); // RULE_10

	property p_wait_pull;
		state_reg == fcs_pkg::FCS_ST_EN_WAIT |-> fanout_pd_o && fanout_clk_oe_o == '0;
	endproperty
	a_wait_pull: assert property (p_wait_pull) else $error("no pull while waiting"); // RULE_10

	property p_en_second;
		state_reg == fcs_pkg::FCS_ST_EN_WAIT && oe_reg && !oe_chg && fall && cnt_reg == last_cnt
			|=> state_reg == fcs_pkg::FCS_ST_RUN && fanout_clk_oe_o == '1;
	endproperty
	a_en_second: assert property (p_en_second) else $error("no start on last fall"); // RULE_10

	property p_no_clk_static;
		state_reg == fcs_pkg::FCS_ST_EN_WAIT && oe_reg && !fall
			|=> state_reg == fcs_pkg::FCS_ST_EN_WAIT && $stable(fanout_clk_o) && fanout_clk_oe_o == '0;
	endproperty
	a_no_clk_static: assert property (p_no_clk_static) else $error("moved without edge"); // RULE_11

	property p_dis_second;
		state_reg == fcs_pkg::FCS_ST_DIS_WAIT && !oe_reg && !oe_chg && fall && cnt_reg == last_cnt
			|=> fanout_clk_oe_o == '1 && fanout_clk_o == '0;
	endproperty
	a_dis_second: assert property (p_dis_second) else $error("not low on last fall"); // RULE_12

	property p_low_to_off;
		state_reg == fcs_pkg::FCS_ST_DIS_LOW && !oe_reg && rise
			|=> fanout_clk_oe_o == '0 && !fanout_pd_o;
	endproperty
	a_low_to_off: assert property (p_low_to_off) else $error("not off after rise"); // RULE_12

	property p_xtal_drive;
		sel_reg == `FCS_SEL_XTAL |=> xtal_drive_out_o == !$past(in_reg.xtal_in);
	endproperty
	a_xtal_drive: assert property (p_xtal_drive) else $error("osc amp wrong"); // RULE_03

endmodule

// *** hdl/fcs_params.svh ***
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// Source choice pin levels
`define FCS_SEL_DIFF    1'b0
`define FCS_SEL_XTAL    1'b1
// Output count and edge count for enable synchronisation
`define FCS_NUM_OUT     5
`define FCS_EDGE_COUNT  2
// Counter width
`define FCS_CNT_W       2
// Nominal period of clk_i in ns
`define FCS_CLK_PERIOD_NS 4

`endif

// *** hdl/fcs_pkg.sv ***
package fcs_pkg;

	// Enable sequencing states
	typedef enum logic [4:0] {
		FCS_ST_OFF     = 5'h01,
		FCS_ST_EN_WAIT = 5'h02,
		FCS_ST_RUN     = 5'h04,
		FCS_ST_DIS_WAIT= 5'h08,
		FCS_ST_DIS_LOW = 5'h10
	} fcs_state_t;

	// Sampled clock input pins
	typedef struct packed {
		logic diff_ref_in_p;
		logic diff_ref_in_n;
		logic xtal_in;
	} fcs_clk_in_t;

endpackage

// *** verif/fcs_fanout_tb.sv ***
`timescale 1ns/1ps

module fcs_fanout_tb;

	logic                 clk_i;
	logic                 rstn_i;
	logic                 sel_i;
	logic                 oe_i;
	logic                 run;
	logic                 look;
	logic [2:0]           lvl;
	fcs_pkg::fcs_clk_in_t pins;
	logic                 xtal_osc_en_o;
	logic                 xtal_drive_out_o;
	logic                 fanout_pd_o;
	logic [4:0]           fanout_clk_o;
	logic [4:0]           fanout_clk_oe_o;
	logic [12:0]          exp_q[$];
	logic [4:0]           tbl [5] = '{5'h00, 5'h09, 5'h04, 5'h11, 5'h12};
	int                   error_cnt = 0;
	int                   total_checks = 0;
	int                   cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	fcs_fanout fcs_fanout_i (
		.clk_i            (clk_i),
		.rstn_i           (rstn_i),
		.sel_i            (sel_i),
		.oe_i             (oe_i),
		.clk_in_i         (pins),
		.xtal_osc_en_o    (xtal_osc_en_o),
		.xtal_drive_out_o (xtal_drive_out_o),
		.fanout_clk_o     (fanout_clk_o),
		.fanout_clk_oe_o  (fanout_clk_oe_o),
		.fanout_pd_o      (fanout_pd_o)
	);

	fcs_src_model fcs_src_model_i (
		.clk_i  (clk_i),
		.run_i  (run),
		.lvl_i  (lvl),
		.pins_o (pins)
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value outputs expected %h seen %h", exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Note order: {osc_en, osc_drive, pull_down, driver_en[5], data[5]}
	task automatic note(input logic [12:0] e);
		exp_q.push_back(e);
		look = 1'b1;
		step(1);
		look = 1'b0;
	endtask

	// Sampled on the falling edge so registered outputs have settled
	always @(negedge clk_i) begin
		if (look === 1'b1) begin
			chk({xtal_osc_en_o, xtal_drive_out_o, fanout_pd_o, fanout_clk_oe_o, fanout_clk_o},
				exp_q.pop_front());
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sel_i  = 1'b0;
		oe_i   = 1'b0;
		run    = 1'b0;
		lvl    = 3'h0;
		look   = 1'b0;
		rstn_i = 1'b0;
		void'($urandom(32'he8fcd756));
		step(6);
		rstn_i = 1'b1;
		step(3);
		note(13'h0000);
		// Enable with no input clock must park on the pull-down
		oe_i = 1'b1;
		step(10);
		note(13'h0400);
		step(10);
		note(13'h0400);
		sel_i = 1'($urandom);
		run   = 1'b1;
		step(24 + $urandom_range(0, 7));
		run = 1'b0;
		// Static levels on each source once running
		for (int i = 0; i < 5; i++) begin
			{sel_i, lvl} = tbl[i][4:1];
			step(6);
			note({sel_i, sel_i & ~lvl[0], 1'b0, 5'h1f, {5{tbl[i][0]}}});
		end
		// Disable with a running clock ends fully off
		sel_i = 1'($urandom);
		run   = 1'b1;
		oe_i  = 1'b0;
		// Crystal mode sees its falls half a period earlier
		step(sel_i ? 15 : 19);
		note({sel_i, 2'b00, 5'h1f, 5'h00});
		step(12);
		run   = 1'b0;
		lvl   = 3'h0;
		sel_i = 1'b0;
		step(6);
		note(13'h0000);
		// Too few falling edges leave the enable pending
		sel_i = 1'($urandom);
		oe_i  = 1'b1;
		run   = 1'b1;
		step(6);
		run = 1'b0;
		step(4);
		note({sel_i, sel_i, 1'b1, 10'h000});
		tally_and_finish();
	end

endmodule

// *** verif/fcs_src_model.sv ***
`timescale 1ns/1ps

module fcs_src_model (
	// Clock and stimulus control
	input  wire logic            clk_i,
	input  wire logic            run_i,
	input  wire logic [2:0]      lvl_i,
	// Source pins
	output fcs_pkg::fcs_clk_in_t pins_o
);

	logic [2:0] phase_reg;
	logic [2:0] phase_next;

	////////////////////////////////////////////////////////////////////////////////
	// Period of eight cycles keeps the oscillator input far below 200 MHz
	always_comb begin
		phase_next = run_i ? phase_reg + 3'h1 : 3'h0;
	end

	always_ff @(posedge clk_i) begin
		phase_reg <= phase_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Both sources always driven; an open oscillator input would oscillate
	always_comb begin
		if (run_i) begin
			pins_o = fcs_pkg::fcs_clk_in_t'({phase_reg[2], ~phase_reg[2], phase_reg[2]});
		end else begin
			pins_o = fcs_pkg::fcs_clk_in_t'(lvl_i);
		end
	end

endmodule
